// *** verilog/swr_consts.vh ***
// Timing and layout constants for the single-wire identity layer
`ifndef SWR_CONSTS_VH
`define SWR_CONSTS_VH
`define SWR_CLK_MHZ        200
// Line low longer than this is a bus reset
`define SWR_T_RST_US       480
`define SWR_RST_CYC        (`SWR_T_RST_US * `SWR_CLK_MHZ)
// Delay from reset release to presence, inside 15..60 us
`define SWR_T_PWAIT_US     30
`define SWR_PWAIT_CYC      (`SWR_T_PWAIT_US * `SWR_CLK_MHZ)
// Presence pulse length, inside 60..240 us
`define SWR_T_PRES_US      120
`define SWR_PRES_CYC       (`SWR_T_PRES_US * `SWR_CLK_MHZ)
// Sample point and drive length of a bit slot
`define SWR_T_SAMP_US      30
`define SWR_SAMP_CYC       (`SWR_T_SAMP_US * `SWR_CLK_MHZ)
// Longest conversion at full resolution
`define SWR_T_CONV12_MS    750
`define SWR_CONV12_CYC     (`SWR_T_CONV12_MS * `SWR_CLK_MHZ * 1000)
// Addressing command codes
`define SWR_CMD_READ_ID    8'h33
`define SWR_CMD_MATCH      8'h55
`define SWR_CMD_SKIP       8'hCC
`define SWR_CMD_SEARCH     8'hF0
`define SWR_CMD_ALM_SEARCH 8'hEC
// Generator x^8+x^5+x^4+1, reflected for LSB-first shifting
`define SWR_CRC_POLY       8'h8C
// Configuration byte: resolution in bits 6:5, fixed bits elsewhere
`define SWR_RES_LSB        5
`define SWR_CFG_RST        8'h7F
`define SWR_CFG_FIXED      5'h1F
`define SWR_RESERVED_BYTE  8'hFF
`endif

// *** verilog/swr_rom_layer.v ***
// Slave-side reset, presence, addressing and CRC layer of a single-wire sensor
`timescale 1ns/10ps
`include "swr_consts.vh"
module swr_rom_layer
#(
  parameter [7:0]  FAMILY    = 8'h5A,            // Arbitrary family value
  parameter [47:0] SERIAL    = 48'h0123456789AB, // Arbitrary serial value
  parameter [16:0] RST_CYC   = `SWR_RST_CYC,
  parameter [16:0] PWAIT_CYC = `SWR_PWAIT_CYC,
  parameter [16:0] PRES_CYC  = `SWR_PRES_CYC,
  parameter [16:0] SAMP_CYC  = `SWR_SAMP_CYC,
  parameter [27:0] CONV_CYC  = `SWR_CONV12_CYC
)
(
  input  wire        i_clock,
  input  wire        i_rst,
  input  wire        i_dq,
  output wire        o_dq,
  output reg         o_dq_oe,
  input  wire        i_cfg_we,
  input  wire [7:0]  i_cfg_data,
  input  wire [7:0]  i_th,
  input  wire [7:0]  i_tl,
  input  wire [15:0] i_temp,
  input  wire        i_conv_done,
  output wire [1:0]  o_resolution,
  output reg  [27:0] o_conv_cycles,
  output reg         o_alarm,
  output reg  [7:0]  o_rom_crc,
  output reg  [7:0]  o_scratch_crc,
  output reg  [7:0]  o_func_cmd,
  output reg         o_func_stb,
  output reg         o_func_active,
  output reg         o_bus_reset
);

  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_PWAIT = 4'h1;
  localparam [3:0] ST_PRES  = 4'h2;
  localparam [3:0] ST_ROM   = 4'h3;
  localparam [3:0] ST_READ  = 4'h4;
  localparam [3:0] ST_MATCH = 4'h5;
  localparam [3:0] ST_SRCH  = 4'h6;
  localparam [3:0] ST_FUNC  = 4'h7;
  localparam [3:0] ST_ACT   = 4'h8;
  localparam [3:0] ST_DONE  = 4'h9;

  // Reflected serial CRC over the low n bits, LSB first
  function [7:0] crc8;
    input [63:0] d;
    input [6:0]  n;
    integer      i;
    reg   [7:0]  c;
    reg          fb;
    begin
      c = 8'h00;
      for (i = 0; i < 64; i = i + 1)
      begin
        if (i < n)
        begin
          fb = c[0] ^ d[i];
          c  = {1'b0, c[7:1]};
          if (fb)
            c = c ^ `SWR_CRC_POLY;
        end
      end
      crc8 = c;
    end
  endfunction

  reg  [1:0]  dq_sync_q;
  reg         dq_prev_q;
  reg  [16:0] cnt_q;
  reg  [3:0]  state_q;
  reg         rst_pend_q;
  reg         slot_q;
  reg  [5:0]  idx_q;
  reg  [1:0]  ph_q;
  reg  [7:0]  sh_q;
  reg         miss_q;
  reg  [7:0]  cfg_q;
  wire        dq_s;
  wire        fall;
  wire        rise;
  wire [63:0] rom_code;
  wire [63:0] scratch;
  wire [7:0]  rom_crc_c;
  wire        tx_mode;
  wire        tx_bit;
  wire        smp;
  wire [7:0]  cmd_byte;

  // Pin input passes two flops before use
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      dq_sync_q <= 2'b11;
      dq_prev_q <= 1'b1;
    end
    else
    begin
      dq_sync_q <= {dq_sync_q[0], i_dq};
      dq_prev_q <= dq_sync_q[1];
    end
  end

  assign dq_s = dq_sync_q[1];
  assign fall = dq_prev_q & ~dq_s;
  assign rise = ~dq_prev_q & dq_s;

  // Time since last line edge, saturating so long idle is harmless
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      cnt_q <= 17'h00000;
    else if (fall | rise)
      cnt_q <= 17'h00000;
    else if (cnt_q != 17'h1FFFF)
      cnt_q <= cnt_q + 17'h00001;
  end

  // identity layout with CRC on top
  assign rom_crc_c = crc8({8'h00, SERIAL, FAMILY}, 7'd56);
  assign rom_code  = {rom_crc_c, SERIAL, FAMILY};

  // only the resolution field is writable
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      cfg_q <= `SWR_CFG_RST;
    else if (i_cfg_we)
      cfg_q <= {1'b0, i_cfg_data[`SWR_RES_LSB+1:`SWR_RES_LSB], `SWR_CFG_FIXED};
  end

  assign o_resolution = cfg_q[`SWR_RES_LSB+1:`SWR_RES_LSB];

  // Scratchpad image: temperature, limits, config, reserved bytes
  assign scratch = {{3{`SWR_RESERVED_BYTE}}, cfg_q, i_tl, i_th, i_temp};

  // CRCs refreshed every cycle, so any change is followed
  // conversion time halves per step below 12 bits
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rom_crc     <= 8'h00;
      o_scratch_crc <= 8'h00;
      o_conv_cycles <= CONV_CYC;
    end
    else
    begin
      o_rom_crc     <= rom_crc_c;
      o_scratch_crc <= crc8(scratch, 7'd64);
      o_conv_cycles <= CONV_CYC >> (2'd3 - o_resolution);
    end
  end

  // alarm re-evaluated on each finished conversion
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      o_alarm <= 1'b0;
    else if (i_conv_done)
      o_alarm <= ($signed(i_temp[11:4]) > $signed(i_th)) |
                 ($signed(i_temp[11:4]) < $signed(i_tl));
  end

  // Transmit phases and the bit being sent
  assign tx_mode = (state_q == ST_READ) | ((state_q == ST_SRCH) & (ph_q != 2'd2));
  assign tx_bit  = (state_q == ST_SRCH && ph_q == 2'd1) ? ~rom_code[idx_q] : rom_code[idx_q];
  assign smp      = slot_q & (cnt_q == SAMP_CYC);
  assign cmd_byte = {dq_s, sh_q[7:1]};
  assign o_dq     = 1'b0;

  // Main sequencer: reset, presence, addressing, function handoff
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q       <= ST_IDLE;
      rst_pend_q    <= 1'b0;
      slot_q        <= 1'b0;
      idx_q         <= 6'd0;
      ph_q          <= 2'd0;
      sh_q          <= 8'h00;
      miss_q        <= 1'b0;
      o_dq_oe       <= 1'b0;
      o_func_cmd    <= 8'h00;
      o_func_stb    <= 1'b0;
      o_func_active <= 1'b0;
      o_bus_reset   <= 1'b0;
    end
    else
    begin
      o_func_stb  <= 1'b0;
      o_bus_reset <= 1'b0;
      if (~dq_s && cnt_q == RST_CYC && ~o_dq_oe)
      begin
        rst_pend_q    <= 1'b1;
        o_bus_reset   <= 1'b1;
        state_q       <= ST_IDLE;
        slot_q        <= 1'b0;
        o_func_active <= 1'b0;
      end
      // release after reset starts the presence sequence
      else if (rise && rst_pend_q)
      begin
        rst_pend_q <= 1'b0;
        state_q    <= ST_PWAIT;
      end
      else
      begin
        case (state_q)
          ST_PWAIT:
          begin
            if (cnt_q == PWAIT_CYC)
            begin
              o_dq_oe <= 1'b1;
              state_q <= ST_PRES;
            end
          end
          ST_PRES:
          begin
            // presence length, counted from our own falling edge
            if (~dq_s && cnt_q == PRES_CYC)
            begin
              o_dq_oe <= 1'b0;
              idx_q   <= 6'd0;
              sh_q    <= 8'h00;
              state_q <= ST_ROM;
            end
          end
          ST_ROM, ST_READ, ST_MATCH, ST_SRCH, ST_FUNC:
          begin
            // slots start only on a falling edge; idle high just waits
            if (fall && ~slot_q)
            begin
              slot_q  <= 1'b1;
              o_dq_oe <= tx_mode & ~tx_bit;
            end
            else if (smp)
            begin
              slot_q  <= 1'b0;
              o_dq_oe <= 1'b0;
              sh_q    <= cmd_byte;
              case (state_q)
                ST_ROM:
                begin
                  idx_q <= idx_q + 6'd1;
                  if (idx_q == 6'd7)
                  begin
                    idx_q  <= 6'd0;
                    ph_q   <= 2'd0;
                    miss_q <= 1'b0;
                    // five commands decoded, anything else ignored
                    case (cmd_byte)
                      `SWR_CMD_READ_ID:    state_q <= ST_READ;
                      `SWR_CMD_MATCH:      state_q <= ST_MATCH;
                      `SWR_CMD_SKIP:       state_q <= ST_FUNC;
                      `SWR_CMD_SEARCH:     state_q <= ST_SRCH;
                      // only with the alarm flag set
                      `SWR_CMD_ALM_SEARCH: state_q <= o_alarm ? ST_SRCH : ST_DONE;
                      default:             state_q <= ST_DONE;
                    endcase
                  end
                end
                ST_READ:
                begin
                  // all 64 bits then the function command
                  idx_q <= idx_q + 6'd1;
                  if (idx_q == 6'd63)
                  begin
                    idx_q   <= 6'd0;
                    state_q <= ST_FUNC;
                  end
                end
                ST_MATCH:
                begin
                  // any differing bit leaves the device silent
                  idx_q <= idx_q + 6'd1;
                  if (idx_q == 6'd63)
                  begin
                    idx_q   <= 6'd0;
                    state_q <= (miss_q | (dq_s != rom_code[63])) ? ST_DONE : ST_FUNC;
                  end
                  else if (dq_s != rom_code[idx_q])
                    miss_q <= 1'b1;
                end
                ST_SRCH:
                begin
                  // third phase reads the master's choice
                  if (ph_q != 2'd2)
                    ph_q <= ph_q + 2'd1;
                  else
                  begin
                    ph_q <= 2'd0;
                    idx_q <= idx_q + 6'd1;
                    // search ends silent until the next reset
                    if (dq_s != rom_code[idx_q] || idx_q == 6'd63)
                      state_q <= ST_DONE;
                  end
                end
                default:
                begin
                  idx_q <= idx_q + 6'd1;
                  if (idx_q == 6'd7)
                  begin
                    o_func_cmd    <= cmd_byte;
                    o_func_stb    <= 1'b1;
                    o_func_active <= 1'b1;
                    state_q       <= ST_ACT;
                  end
                end
              endcase
            end
          end
          // no CRC check anywhere; idle states wait for reset
          default:
          begin
            slot_q  <= 1'b0;
            o_dq_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// *** sim/swr_rom_layer_monitor.sv ***
// Port assertions for the single-wire identity layer
`timescale 1ns/10ps
module swr_rom_monitor
#(
  parameter [16:0] RST_CYC  = 17'd96000,
  parameter [27:0] CONV_CYC = 28'd150000000
)
(
  input wire        i_clock,
  input wire        i_rst,
  input wire        i_dq,
  input wire        o_dq,
  input wire        o_dq_oe,
  input wire        i_cfg_we,
  input wire [7:0]  i_cfg_data,
  input wire [7:0]  i_th,
  input wire [7:0]  i_tl,
  input wire [15:0] i_temp,
  input wire        i_conv_done,
  input wire [1:0]  o_resolution,
  input wire [27:0] o_conv_cycles,
  input wire        o_alarm,
  input wire        o_func_stb,
  input wire        o_func_active,
  input wire        o_bus_reset
);
  reg  [16:0] low_q;
  wire [7:0]  t8  = i_temp[11:4];
  wire        alm = $signed(t8) > $signed(i_th) || $signed(t8) < $signed(i_tl);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Raw low stretch; saturates so a stuck line cannot wrap to zero
  always @(posedge i_clock or posedge i_rst)
    if (i_rst)
      low_q <= 17'd0;
    else if (i_dq)
      low_q <= 17'd0;
    else if (~&low_q)
      low_q <= low_q + 17'd1;
  property p_od; o_dq_oe |-> !o_dq && !i_dq; endproperty
  a_od: assert property (p_od) else $error("line not pulled low");
  property p_rlen; o_bus_reset |-> low_q >= RST_CYC; endproperty
  a_rlen: assert property (p_rlen) else $error("early bus reset");
  property p_clr; o_bus_reset |-> ##[0:2] !o_func_active; endproperty
  a_clr: assert property (p_clr) else $error("select kept");
  property p_pwait; o_bus_reset |-> !o_dq_oe [*8]; endproperty
  a_pwait: assert property (p_pwait) else $error("early presence");
  property p_stb; o_func_stb |=> !o_func_stb; endproperty
  a_stb: assert property (p_stb) else $error("long strobe");
  property p_act; o_func_stb |-> o_func_active; endproperty
  a_act: assert property (p_act) else $error("strobe unselected");
  property p_res; i_cfg_we |=> o_resolution == $past(i_cfg_data[6:5]); endproperty
  a_res: assert property (p_res) else $error("resolution");
  property p_conv;
    i_cfg_we |-> ##2 o_conv_cycles == (CONV_CYC >> (2'd3 - $past(i_cfg_data[6:5], 2)));
  endproperty
  a_conv: assert property (p_conv) else $error("conversion time");
  property p_alm; i_conv_done |=> o_alarm == $past(alm); endproperty
  a_alm: assert property (p_alm) else $error("alarm flag");
  c_stb: cover property (o_func_stb);
  c_brst: cover property (o_bus_reset);
  c_alm: cover property (i_conv_done && alm);
endmodule
bind swr_rom_layer swr_rom_monitor #(.RST_CYC(RST_CYC), .CONV_CYC(CONV_CYC)) u_mon (
  .i_clock(i_clock), .i_rst(i_rst), .i_dq(i_dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
  .i_cfg_we(i_cfg_we), .i_cfg_data(i_cfg_data), .i_th(i_th), .i_tl(i_tl),
  .i_temp(i_temp), .i_conv_done(i_conv_done), .o_resolution(o_resolution),
  .o_conv_cycles(o_conv_cycles), .o_alarm(o_alarm), .o_func_stb(o_func_stb),
  .o_func_active(o_func_active), .o_bus_reset(o_bus_reset));

// *** sim/swr_master_model.sv ***
// Bus master model driving the open-drain data line in clock cycles
`timescale 1ns/10ps
module swr_master_model
(
  input  wire i_clock,
  input  wire i_line,
  output reg  o_pull
);
  initial o_pull = 1'b0;
  task hold(input integer n);
    repeat (n) @(posedge i_clock);
  endtask
  // strong pull-up: line left high for the conversion
  task convert_hold(input integer n);
    begin
      @(posedge i_clock);
      o_pull <= 1'b0;
      hold(n);
    end
  endtask
  // long low, release, sample presence early in the pulse
  task bus_reset(output reg pres);
    begin
      @(posedge i_clock);
      o_pull <= 1'b1;
      hold(230);
      o_pull <= 1'b0;
      hold(35);
      pres = i_line;
      hold(120);
    end
  endtask
  // short low for a one, full slot low for a zero
  task wbit(input b);
    begin
      @(posedge i_clock);
      o_pull <= 1'b1;
      hold(b ? 4 : 40);
      o_pull <= 1'b0;
      hold(b ? 41 : 5);
    end
  endtask
  // Brief low, then release and sample what the device holds
  task rbit(output reg b);
    begin
      @(posedge i_clock);
      o_pull <= 1'b1;
      hold(2);
      o_pull <= 1'b0;
      hold(13);
      b = i_line;
      hold(32);
    end
  endtask
  task wbyte(input [7:0] v);
    integer i;
    for (i = 0; i < 8; i = i + 1)
      wbit(v[i]);
  endtask
endmodule

// *** sim/swr_rom_layer_tb_top.sv ***
// Self-checking bench for the single-wire identity layer
`timescale 1ns/10ps
module swr_rom_layer_tb_top;
  localparam [7:0]  FAM  = 8'h5A;            // Arbitrary family value, block default kept
  localparam [47:0] SER  = 48'h1122334455AA; // Arbitrary serial value
  localparam [27:0] CONV = 28'd150000000;
  reg         i_clock = 1'b0;
  reg         i_rst = 1'b1;
  reg         i_cfg_we = 1'b0;
  reg  [7:0]  i_cfg_data = 8'h00;
  reg  [7:0]  i_th = 8'h19;
  reg  [7:0]  i_tl = 8'h05;
  reg  [15:0] i_temp = 16'h0550;
  reg         i_conv_done = 1'b0;
  wire        pull, o_dq, o_dq_oe, o_alarm, o_stb, o_act, o_brst;
  wire [1:0]  o_res;
  wire [27:0] o_conv;
  wire [7:0]  o_rcrc, o_scrc, o_cmd;
  // pull-up wins unless someone sinks the line
  wire        line = ~(pull | (o_dq_oe & ~o_dq));
  integer     fails = 0;
  integer     tests_run = 0;
  integer     stbs = 0;
  integer     brsts = 0;
  reg  [1:0]  rx;
  integer     k, n0;
  reg  [63:0] id;
  reg         b, b2;
  swr_rom_layer #(.SERIAL(SER), .RST_CYC(17'd200), .PWAIT_CYC(17'd20),
    .PRES_CYC(17'd50), .SAMP_CYC(17'd30)) DUT (.i_clock(i_clock), .i_rst(i_rst),
    .i_dq(line), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_cfg_we(i_cfg_we),
    .i_cfg_data(i_cfg_data), .i_th(i_th), .i_tl(i_tl), .i_temp(i_temp),
    .i_conv_done(i_conv_done), .o_resolution(o_res), .o_conv_cycles(o_conv),
    .o_alarm(o_alarm), .o_rom_crc(o_rcrc), .o_scratch_crc(o_scrc), .o_func_cmd(o_cmd),
    .o_func_stb(o_stb), .o_func_active(o_act), .o_bus_reset(o_brst));
  swr_master_model m (.i_clock(i_clock), .i_line(line), .o_pull(pull));
  always #2.5 i_clock = ~i_clock;
  // Count one-cycle strobes: function command and bus reset
  always @(posedge i_clock)
  begin
    if (o_stb === 1'b1)
      stbs = stbs + 1;
    if (o_brst === 1'b1)
      brsts = brsts + 1;
  end
  // cleared register, data shifted in from bit 0
  function [7:0] crc_n(input [63:0] d, input integer n);
    integer i;
    begin
      crc_n = 8'h00;
      for (i = 0; i < n; i = i + 1)
        crc_n = {1'b0, crc_n[7:1]} ^ ((crc_n[0] ^ d[i]) ? 8'h8C : 8'h00);
    end
  endfunction
  task check(input [63:0] seen, input [63:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
        fails = fails + 1;
        $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // All four resolution codes, then the scratch CRC after two limit edits
  task t_config;
    begin
      check(o_res, 2'b11);
      check(o_conv, CONV);
      for (k = 0; k < 6; k = k + 1)
      begin
        @(posedge i_clock);
        i_cfg_we <= (k < 4);
        i_cfg_data <= {1'b1, k[1:0], 5'h00};
        i_th <= 8'h17 + k[7:0];
        @(posedge i_clock);
        i_cfg_we <= 1'b0;
        repeat (4) @(posedge i_clock);
        rx = (k < 4) ? k[1:0] : 2'b11;
        check(o_res, rx);
        check(o_conv, CONV >> (3 - rx));
        check(o_scrc, crc_n({24'hFFFFFF, 1'b0, rx, 5'h1F, i_tl, i_th, i_temp}, 64));
      end
    end
  endtask
  // Identity read, long idle, then the function byte is still taken
  task t_id;
    begin
      m.bus_reset(b);
      check(b, 1'b0);
      m.wbyte(8'h33);
      for (k = 0; k < 64; k = k + 1)
      begin
        m.rbit(b);
        id[k] = b;
      end
      check(id[55:0], {SER, FAM});
      check(id[63:56], crc_n(id, 56));
      check(crc_n(id, 64), 8'h00);
      check(o_rcrc, id[63:56]);
      repeat (3000) @(posedge i_clock);
      n0 = stbs;
      m.wbyte(8'hBE);
      repeat (4) @(posedge i_clock);
      check(stbs - n0, 1);
      check(o_cmd, 8'hBE);
    end
  endtask
  // Addressing command, optional code bits, function byte, strobe count
  task t_func(input [7:0] rc, input [63:0] code, input integer nb, input [7:0] fc,
              input en);
    begin
      n0 = brsts;
      m.bus_reset(b);
      check(brsts - n0, 1);
      check(b, 1'b0);
      m.wbyte(rc);
      for (k = 0; k < nb; k = k + 1)
        m.wbit(code[k]);
      n0 = stbs;
      m.wbyte(fc);
      repeat (4) @(posedge i_clock);
      check(stbs - n0, en);
      check(o_act, en);
    end
  endtask
  // Conversion result, then one search step and a losing choice
  task t_search(input [7:0] rc, input [15:0] temp, input [7:0] tl, input al, input resp);
    begin
      m.convert_hold(8);
      check(line, 1'b1);
      i_temp <= temp;
      i_tl <= tl;
      i_conv_done <= 1'b1;
      @(posedge i_clock);
      i_conv_done <= 1'b0;
      repeat (2) @(posedge i_clock);
      check(o_alarm, al);
      m.bus_reset(b);
      m.wbyte(rc);
      m.rbit(b);
      m.rbit(b2);
      check({b, b2}, resp ? {FAM[0], ~FAM[0]} : 2'b11);
      m.wbit(~FAM[0]);
      m.rbit(b);
      m.rbit(b2);
      check({b, b2}, 2'b11);
    end
  endtask
  // Main sequence; every search starts with a fresh reset
  initial
  begin
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clock);
    t_config;
    t_id;
    t_func(8'hCC, 64'h0, 0, 8'h44, 1'b1);
    t_func(8'hCC, 64'h0, 0, 8'hBE, 1'b1);
    t_func(8'h55, {crc_n({SER, FAM}, 56), SER, FAM}, 64, 8'h4E, 1'b1);
    t_func(8'h55, {crc_n({SER, FAM}, 56), SER ^ 48'h1, FAM}, 64, 8'h48, 1'b0);
    t_func(8'h44, 64'h0, 0, 8'hB8, 1'b0);
    t_search(8'hEC, 16'hFF5E, 8'h05, 1'b1, 1'b1);
    t_search(8'hF0, 16'h0550, 8'h05, 1'b1, 1'b1);
    t_search(8'hEC, 16'h0100, 8'h11, 1'b1, 1'b1);
    t_search(8'hEC, 16'h0100, 8'hF0, 1'b0, 1'b0);
    results;
  end
  // Watchdog, about three and a half times the expected run
  initial
  begin
    #400000;
    fails = fails + 1;
    results;
  end
endmodule
